// ==== shared/tick_counter_pkg.sv ====
// constants, register indices and field layout of the 24-bit tick counter
// assumes byte-wide registers, one per aligned 32-bit AXI4-Lite word
package tick_counter_pkg;
   localparam int          COUNT_W        = 24;
   localparam int          AXI_ADDR_W     = 18;
   localparam int          AXI_DATA_W     = 32;
   localparam int          IDX_W          = 16;
   localparam int          IDX_LSB        = 2;
   localparam int          PRESCALE_W     = 3;

   // register index; byte address is four times the index
   localparam logic [15:0] IDX_CTRL_ONE   = 16'hA100;
   localparam logic [15:0] IDX_CTRL_TWO   = 16'hA101;
   localparam logic [15:0] IDX_COUNT_LOW  = 16'hA102;
   localparam logic [15:0] IDX_COUNT_MID  = 16'hA103;
   localparam logic [15:0] IDX_COUNT_HIGH = 16'hA104;
   localparam logic [15:0] IDX_RELOAD_LOW = 16'hA105;
   localparam logic [15:0] IDX_RELOAD_MID = 16'hA106;
   localparam logic [15:0] IDX_RELOAD_HI  = 16'hA107;
   localparam logic [15:0] IDX_CMP_LOW    = 16'hA018;
   localparam logic [15:0] IDX_CMP_MID    = 16'hA019;
   localparam logic [15:0] IDX_CMP_HIGH   = 16'hA01A;
   localparam logic [15:0] IDX_SNAP0_LOW  = 16'hA110;
   localparam logic [15:0] IDX_SNAP0_MID  = 16'hA111;
   localparam logic [15:0] IDX_SNAP0_HIGH = 16'hA112;
   localparam logic [15:0] IDX_SNAP1_LOW  = 16'hA113;
   localparam logic [15:0] IDX_SNAP1_MID  = 16'hA114;
   localparam logic [15:0] IDX_SNAP1_HIGH = 16'hA115;
   localparam logic [15:0] IDX_SNAP_CTRL  = 16'hA117;

   // control one: flags and prescale
   localparam int          MATCH_TWO_FLAG_BIT   = 7;
   localparam int          MATCH_ONE_FLAG_BIT   = 6;
   localparam int          PRESCALE_HI_BIT      = 1;
   // control two: enables and modes
   localparam int          MATCH_TWO_EN_BIT     = 7;
   localparam int          MATCH_ONE_EN_BIT     = 6;
   localparam int          INIT_FROM_RELOAD_BIT = 2;
   localparam int          RUN_BIT              = 1;
   localparam int          AUTO_RELOAD_BIT      = 0;
   // snapshot trigger control
   localparam int          SOFT_TRIG_ZERO_BIT   = 7;
   localparam int          SOFT_TRIG_ONE_BIT    = 6;
   localparam int          SOFT_SEL_ZERO_BIT    = 5;
   localparam int          SOFT_SEL_ONE_BIT     = 4;

   localparam logic [1:0]  PRESCALE_DIV8  = 2'h0;
   localparam logic [1:0]  PRESCALE_DIV4  = 2'h1;
   localparam logic [1:0]  PRESCALE_DIV2  = 2'h2;
   localparam logic [2:0]  MASK_DIV8      = 3'h7;
   localparam logic [2:0]  MASK_DIV4      = 3'h3;
   localparam logic [2:0]  MASK_DIV2      = 3'h1;
   localparam logic [2:0]  MASK_DIV1      = 3'h0;

   localparam logic [23:0] COUNT_MAX      = 24'hFFFFFF;
   localparam logic [23:0] COUNT_ZERO     = 24'h000000;
   localparam logic [7:0]  BYTE_ZERO      = 8'h00;
   localparam logic [1:0]  RESP_OKAY      = 2'h0;
   localparam logic [1:0]  RESP_SLVERR    = 2'h2;

   function automatic logic [15:0] reg_index(input logic [AXI_ADDR_W-1:0] addr);
      return addr[AXI_ADDR_W-1:IDX_LSB];
   endfunction

   function automatic logic [7:0] byte_of(input logic [23:0] v, input int n);
      return v[n*8 +: 8];
   endfunction

   function automatic logic [23:0] put_byte(input logic [23:0] v, input int n,
                                            input logic [7:0] b);
      logic [23:0] r;
      r = v;
      r[n*8 +: 8] = b;
      return r;
   endfunction
endpackage

// ==== hdl/tick_prescaler.sv ====
// divider that turns the system clock into the counter's advance tick
// assumes run and sel come from registers in the same clock domain
`timescale 1ns/1ns
module tick_prescaler
   import tick_counter_pkg::*;
#(
   parameter int DIV_W = PRESCALE_W
) (
   input  wire logic       aclk,    // system clock
   input  wire logic       aresetn, // synchronous reset, active low
   input  wire logic       run,     // counting enabled
   input  wire logic [1:0] sel,     // prescale select
   output logic            tick     // one-cycle advance strobe
);
   logic [DIV_W-1:0] div_reg;
   logic [DIV_W-1:0] div_next;
   logic [DIV_W-1:0] div_mask;

   // held at zero while stopped, so the first tick comes right at start
   assign div_next = run ? DIV_W'(div_reg + 1'b1) : '0;
   assign div_mask = (sel == PRESCALE_DIV8) ? MASK_DIV8 :
                     (sel == PRESCALE_DIV4) ? MASK_DIV4 :
                     (sel == PRESCALE_DIV2) ? MASK_DIV2 : MASK_DIV1;
   assign tick     = run && ((div_reg & div_mask) == '0);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         div_reg <= '0;
      end else begin
         div_reg <= div_next;
      end
   end
endmodule

// ==== hdl/tick_counter.sv ====
// 24-bit tick counter with reload, two compares and two snapshots
// assumes an AXI4-Lite master on aclk and external irq inputs synchronous to aclk
// Notes on behaviour
// - count bytes read the live 24-bit count
// - low-byte write initialises counter, data discarded
// - middle and high count bytes read-only
// - 24-bit reload value, also second compare; code skips the second compare in auto-reload mode
// - separate 24-bit first compare, reset zero
// - two snapshot holders copy whole count
// - snapshot zero: software or irq zero
// - snapshot one: software or irq one
// - bit 7 write triggers snapshot zero
// - bit 6 write triggers snapshot one
// - bit 5 picks software or irq zero
// - bit 4 picks software or irq one
// - trigger bits read zero, low nibble unused
// - snapshot bytes read-only, reset zero
// - overflow reloads in auto mode, else wraps
// - init select picks reload or zero
// - prescale select divides clock by 8/4/2/1
// - first compare match sets sticky flag, irq
//
// The implementer's own choice: the AXI4-Lite register port.
`timescale 1ns/1ns
module tick_counter
   import tick_counter_pkg::*;
(
   input  wire logic                  aclk,         // system clock
   input  wire logic                  aresetn,      // synchronous reset, active low
   input  wire logic [AXI_ADDR_W-1:0] awaddr,       // write address
   input  wire logic                  awvalid,      // write address valid
   output logic                       awready,      // write address ready
   input  wire logic [AXI_DATA_W-1:0] wdata,        // write data
   input  wire logic [3:0]            wstrb,        // write byte strobes
   input  wire logic                  wvalid,       // write data valid
   output logic                       wready,       // write data ready
   output logic [1:0]                 bresp,        // write response
   output logic                       bvalid,       // write response valid
   input  wire logic                  bready,       // write response ready
   input  wire logic [AXI_ADDR_W-1:0] araddr,       // read address
   input  wire logic                  arvalid,      // read address valid
   output logic                       arready,      // read address ready
   output logic [AXI_DATA_W-1:0]      rdata,        // read data
   output logic [1:0]                 rresp,        // read response
   output logic                       rvalid,       // read data valid
   input  wire logic                  rready,       // read data ready
   input  wire logic                  ext_irq_zero, // external interrupt zero request
   input  wire logic                  ext_irq_one,  // external interrupt one request
   output logic                       timer_irq     // timer interrupt request
);
   logic [AXI_ADDR_W-1:0] awaddr_reg;
   logic [7:0]            wbyte_reg;
   logic                  wlane_reg;
   logic                  aw_held_reg, w_held_reg;
   logic                  awready_reg, wready_reg, bvalid_reg, arready_reg, rvalid_reg;
   logic [1:0]            bresp_reg, rresp_reg;
   logic [AXI_DATA_W-1:0] rdata_reg;
   logic                  timer_irq_reg;

   logic [COUNT_W-1:0]    count_reg, count_next;
   logic [COUNT_W-1:0]    reload_reg, reload_next;
   logic [COUNT_W-1:0]    cmp_reg, cmp_next;
   logic [COUNT_W-1:0]    snap_zero_holder_reg, snap_one_holder_reg;
   logic [1:0]            prescale_reg;
   logic                  match_one_flag_reg, match_two_flag_reg;
   logic                  match_one_enable_reg, match_two_enable_reg;
   logic                  init_from_reload_reg, run_reg, auto_reload_mode_reg;
   logic                  soft_sel_zero_reg, soft_sel_one_reg;
   logic                  irq_zero_prev_reg, irq_one_prev_reg;

   // write channel decode
   logic                  aw_fire, w_fire, wr_fire;
   logic                  aw_held_next, w_held_next, bvalid_next;
   logic [15:0]           wr_idx;
   logic                  wr_byte;
   logic                  wr_ctrl_one, wr_ctrl_two, wr_snap_ctrl, init_wr;
   logic                  wr_rl_l, wr_rl_m, wr_rl_h, wr_cmp_l, wr_cmp_m, wr_cmp_h;
   logic                  wr_mapped;
   // read channel decode
   logic                  ar_fire;
   logic [15:0]           rd_idx;
   logic [7:0]            rd_byte;
   logic                  rd_mapped;
   // counter and events
   logic                  tick, at_max;
   logic [COUNT_W-1:0]    init_value, wrap_value;
   logic                  irq_zero_rise, irq_one_rise;
   logic                  cap_zero, cap_one;
   logic                  hit_one, hit_two;
   logic                  clr_one, clr_two;

   assign aw_fire      = awvalid && awready_reg;
   assign w_fire       = wvalid && wready_reg;
   assign wr_fire      = aw_held_reg && w_held_reg && !bvalid_reg;
   assign aw_held_next = (aw_held_reg || aw_fire) && !wr_fire;
   assign w_held_next  = (w_held_reg || w_fire) && !wr_fire;
   assign bvalid_next  = wr_fire || (bvalid_reg && !bready);
   assign wr_idx       = reg_index(awaddr_reg);
   // only lane zero carries a register byte; other lanes are ignored
   assign wr_byte      = wr_fire && wlane_reg;
   assign wr_ctrl_one  = wr_byte && (wr_idx == IDX_CTRL_ONE);
   assign wr_ctrl_two  = wr_byte && (wr_idx == IDX_CTRL_TWO);
   assign wr_snap_ctrl = wr_byte && (wr_idx == IDX_SNAP_CTRL);
   assign init_wr      = wr_byte && (wr_idx == IDX_COUNT_LOW);
   assign wr_rl_l      = wr_byte && (wr_idx == IDX_RELOAD_LOW);
   assign wr_rl_m      = wr_byte && (wr_idx == IDX_RELOAD_MID);
   assign wr_rl_h      = wr_byte && (wr_idx == IDX_RELOAD_HI);
   assign wr_cmp_l     = wr_byte && (wr_idx == IDX_CMP_LOW);
   assign wr_cmp_m     = wr_byte && (wr_idx == IDX_CMP_MID);
   assign wr_cmp_h     = wr_byte && (wr_idx == IDX_CMP_HIGH);
   assign wr_mapped    = is_mapped(wr_idx);

   assign ar_fire      = arvalid && arready_reg;
   assign rd_idx       = reg_index(araddr);
   assign rd_mapped    = is_mapped(rd_idx);
   assign rd_byte      = read_byte(rd_idx);

   function automatic logic is_mapped(input logic [15:0] idx);
      return (idx >= IDX_CTRL_ONE && idx <= IDX_RELOAD_HI) ||
             (idx >= IDX_CMP_LOW && idx <= IDX_CMP_HIGH) ||
             (idx >= IDX_SNAP0_LOW && idx <= IDX_SNAP1_HIGH) ||
             (idx == IDX_SNAP_CTRL);
   endfunction

   function automatic logic [7:0] read_byte(input logic [15:0] idx);
      logic [7:0] b;
      b = BYTE_ZERO;
      unique case (idx)
         IDX_CTRL_ONE: begin
            b[MATCH_TWO_FLAG_BIT]          = match_two_flag_reg;
            b[MATCH_ONE_FLAG_BIT]          = match_one_flag_reg;
            b[PRESCALE_HI_BIT:0]           = prescale_reg;
         end
         IDX_CTRL_TWO: begin
            b[MATCH_TWO_EN_BIT]            = match_two_enable_reg;
            b[MATCH_ONE_EN_BIT]            = match_one_enable_reg;
            b[INIT_FROM_RELOAD_BIT]        = init_from_reload_reg;
            b[RUN_BIT]                     = run_reg;
            b[AUTO_RELOAD_BIT]             = auto_reload_mode_reg;
         end
         IDX_COUNT_LOW:  b = byte_of(count_reg, 0);
         IDX_COUNT_MID:  b = byte_of(count_reg, 1);
         IDX_COUNT_HIGH: b = byte_of(count_reg, 2);
         IDX_RELOAD_LOW: b = byte_of(reload_reg, 0);
         IDX_RELOAD_MID: b = byte_of(reload_reg, 1);
         IDX_RELOAD_HI:  b = byte_of(reload_reg, 2);
         IDX_CMP_LOW:    b = byte_of(cmp_reg, 0);
         IDX_CMP_MID:    b = byte_of(cmp_reg, 1);
         IDX_CMP_HIGH:   b = byte_of(cmp_reg, 2);
         IDX_SNAP0_LOW:  b = byte_of(snap_zero_holder_reg, 0);
         IDX_SNAP0_MID:  b = byte_of(snap_zero_holder_reg, 1);
         IDX_SNAP0_HIGH: b = byte_of(snap_zero_holder_reg, 2);
         IDX_SNAP1_LOW:  b = byte_of(snap_one_holder_reg, 0);
         IDX_SNAP1_MID:  b = byte_of(snap_one_holder_reg, 1);
         IDX_SNAP1_HIGH: b = byte_of(snap_one_holder_reg, 2);
         IDX_SNAP_CTRL: begin
            // trigger bits and low nibble read as zero
            b[SOFT_SEL_ZERO_BIT]           = soft_sel_zero_reg;
            b[SOFT_SEL_ONE_BIT]            = soft_sel_one_reg;
         end
         default:        b = BYTE_ZERO;
      endcase
      return b;
   endfunction

   tick_prescaler u_prescaler (
      .aclk    (aclk),
      .aresetn (aresetn),
      .run     (run_reg),
      .sel     (prescale_reg),
      .tick    (tick)
   );

   assign at_max      = (count_reg == COUNT_MAX);
   assign init_value  = init_from_reload_reg ? reload_reg : COUNT_ZERO;
   assign wrap_value  = auto_reload_mode_reg ? reload_reg : COUNT_ZERO;
   // the init write wins; the next tick counts from the loaded value
   assign count_next  = init_wr ? init_value :
                        !tick   ? count_reg :
                        at_max  ? wrap_value : COUNT_W'(count_reg + 1'b1);
   assign reload_next = wr_rl_l ? put_byte(reload_reg, 0, wbyte_reg) :
                        wr_rl_m ? put_byte(reload_reg, 1, wbyte_reg) :
                        wr_rl_h ? put_byte(reload_reg, 2, wbyte_reg) : reload_reg;
   assign cmp_next    = wr_cmp_l ? put_byte(cmp_reg, 0, wbyte_reg) :
                        wr_cmp_m ? put_byte(cmp_reg, 1, wbyte_reg) :
                        wr_cmp_h ? put_byte(cmp_reg, 2, wbyte_reg) : cmp_reg;

   assign irq_zero_rise = ext_irq_zero && !irq_zero_prev_reg;
   assign irq_one_rise  = ext_irq_one && !irq_one_prev_reg;
   // the select in force before the write decides, so one write cannot both arm and fire
   assign cap_zero = soft_sel_zero_reg ? (wr_snap_ctrl && wbyte_reg[SOFT_TRIG_ZERO_BIT])
                                       : irq_zero_rise;
   assign cap_one  = soft_sel_one_reg  ? (wr_snap_ctrl && wbyte_reg[SOFT_TRIG_ONE_BIT])
                                       : irq_one_rise;

   assign hit_one = match_one_enable_reg && (count_reg == cmp_reg);
   assign hit_two = match_two_enable_reg && !auto_reload_mode_reg && (count_reg == reload_reg);
   assign clr_one = wr_ctrl_one && !wbyte_reg[MATCH_ONE_FLAG_BIT];
   assign clr_two = wr_ctrl_one && !wbyte_reg[MATCH_TWO_FLAG_BIT];

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         awaddr_reg  <= '0;
         wbyte_reg   <= BYTE_ZERO;
         wlane_reg   <= 1'b0;
         aw_held_reg <= 1'b0;
         w_held_reg  <= 1'b0;
         awready_reg <= 1'b0;
         wready_reg  <= 1'b0;
         bvalid_reg  <= 1'b0;
         bresp_reg   <= RESP_OKAY;
      end else begin
         if (aw_fire) begin
            awaddr_reg <= awaddr;
         end
         if (w_fire) begin
            wbyte_reg <= wdata[7:0];
            wlane_reg <= wstrb[0];
         end
         if (wr_fire) begin
            bresp_reg <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
         end
         aw_held_reg <= aw_held_next;
         w_held_reg  <= w_held_next;
         bvalid_reg  <= bvalid_next;
         awready_reg <= !aw_held_next && !bvalid_next;
         wready_reg  <= !w_held_next && !bvalid_next;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready_reg <= 1'b0;
         rvalid_reg  <= 1'b0;
         rdata_reg   <= '0;
         rresp_reg   <= RESP_OKAY;
      end else if (ar_fire) begin
         arready_reg <= 1'b0;
         rvalid_reg  <= 1'b1;
         rdata_reg   <= {{(AXI_DATA_W-8){1'b0}}, rd_byte};
         rresp_reg   <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
      end else begin
         if (rvalid_reg && rready) begin
            rvalid_reg <= 1'b0;
         end
         arready_reg <= !rvalid_reg || rready;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         count_reg            <= COUNT_ZERO;
         reload_reg           <= COUNT_ZERO;
         cmp_reg              <= COUNT_ZERO;
         snap_zero_holder_reg <= COUNT_ZERO;
         snap_one_holder_reg  <= COUNT_ZERO;
         irq_zero_prev_reg    <= 1'b0;
         irq_one_prev_reg     <= 1'b0;
      end else begin
         count_reg         <= count_next;
         reload_reg        <= reload_next;
         cmp_reg           <= cmp_next;
         irq_zero_prev_reg <= ext_irq_zero;
         irq_one_prev_reg  <= ext_irq_one;
         if (cap_zero) begin
            snap_zero_holder_reg <= count_reg;
         end
         if (cap_one) begin
            snap_one_holder_reg <= count_reg;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         prescale_reg         <= PRESCALE_DIV8;
         match_one_enable_reg <= 1'b0;
         match_two_enable_reg <= 1'b0;
         init_from_reload_reg <= 1'b0;
         run_reg              <= 1'b0;
         auto_reload_mode_reg <= 1'b0;
         soft_sel_zero_reg    <= 1'b0;
         soft_sel_one_reg     <= 1'b0;
         match_one_flag_reg   <= 1'b0;
         match_two_flag_reg   <= 1'b0;
         timer_irq_reg        <= 1'b0;
      end else begin
         if (wr_ctrl_one) begin
            prescale_reg <= wbyte_reg[PRESCALE_HI_BIT:0];
         end
         if (wr_ctrl_two) begin
            match_two_enable_reg <= wbyte_reg[MATCH_TWO_EN_BIT];
            match_one_enable_reg <= wbyte_reg[MATCH_ONE_EN_BIT];
            init_from_reload_reg <= wbyte_reg[INIT_FROM_RELOAD_BIT];
            run_reg              <= wbyte_reg[RUN_BIT];
            auto_reload_mode_reg <= wbyte_reg[AUTO_RELOAD_BIT];
         end
         if (wr_snap_ctrl) begin
            soft_sel_zero_reg <= wbyte_reg[SOFT_SEL_ZERO_BIT];
            soft_sel_one_reg  <= wbyte_reg[SOFT_SEL_ONE_BIT];
         end
         // a match in the clearing cycle keeps the flag set
         match_one_flag_reg <= hit_one || (match_one_flag_reg && !clr_one);
         match_two_flag_reg <= hit_two || (match_two_flag_reg && !clr_two);
         timer_irq_reg      <= match_one_flag_reg || match_two_flag_reg;
      end
   end

   assign awready   = awready_reg;
   assign wready    = wready_reg;
   assign bvalid    = bvalid_reg;
   assign bresp     = bresp_reg;
   assign arready   = arready_reg;
   assign rvalid    = rvalid_reg;
   assign rdata     = rdata_reg;
   assign rresp     = rresp_reg;
   assign timer_irq = timer_irq_reg;

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   chk_init_zero: assert property (init_wr && !init_from_reload_reg |=> count_reg == COUNT_ZERO)
      else $error("init write did not clear counter");
   chk_init_reload: assert property (init_wr && init_from_reload_reg
                                     |=> count_reg == $past(reload_reg))
      else $error("init write did not load reload value");
   chk_init_wins: assert property (init_wr && tick && at_max |=> count_reg == $past(init_value))
      else $error("count advanced over init write");
   chk_wrap_free: assert property (tick && at_max && !init_wr && !auto_reload_mode_reg
                                   |=> count_reg == COUNT_ZERO)
      else $error("free-run overflow did not wrap to zero");
   chk_wrap_reload: assert property (tick && at_max && !init_wr && auto_reload_mode_reg
                                     |=> count_reg == $past(reload_reg))
      else $error("auto mode overflow did not reload");
   chk_mid_readonly: assert property (wr_fire && wr_idx == IDX_COUNT_MID && !tick
                                      |=> $stable(count_reg))
      else $error("write to middle count byte changed counter");
   chk_read_live: assert property (ar_fire && rd_idx == IDX_COUNT_LOW
                                   |=> rvalid && rdata[7:0] == $past(count_reg[7:0]))
      else $error("low count read not live value");
   chk_ssc_read: assert property (ar_fire && rd_idx == IDX_SNAP_CTRL
                                  |=> rdata[SOFT_TRIG_ZERO_BIT:SOFT_TRIG_ONE_BIT] == 2'h0
                                      && rdata[3:0] == 4'h0)
      else $error("snapshot control read back trigger or low bits");
   chk_hw_snap_zero: assert property (irq_zero_rise && !soft_sel_zero_reg
                                      |=> snap_zero_holder_reg == $past(count_reg))
      else $error("irq zero snapshot missed");
   chk_sw_snap_one: assert property (wr_snap_ctrl && soft_sel_one_reg
                                     && wbyte_reg[SOFT_TRIG_ONE_BIT]
                                     |=> snap_one_holder_reg == $past(count_reg))
      else $error("software snapshot one missed");
   chk_hw_blocked: assert property (soft_sel_one_reg && !wr_snap_ctrl
                                    |=> $stable(snap_one_holder_reg))
      else $error("snapshot one changed without software trigger");
   chk_snap_hold: assert property (!cap_zero |=> $stable(snap_zero_holder_reg))
      else $error("snapshot zero changed without capture");
   chk_match_irq: assert property (hit_one |=> match_one_flag_reg ##1 timer_irq)
      else $error("compare match did not raise flag and irq");
endmodule

// ==== test/testbench.sv ====
// self-checking bench for the tick counter, driven over AXI4-Lite
// assumes the package register map, byte address four times the index
`timescale 1ns/1ns
module testbench;
   import tick_counter_pkg::*;
   logic                  aclk = 1'b0;
   logic                  aresetn = 1'b0;
   logic                  awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
   logic                  arvalid = 1'b0, rready = 1'b0;
   logic                  ext_irq_zero = 1'b0, ext_irq_one = 1'b0;
   logic [AXI_ADDR_W-1:0] awaddr = '0, araddr = '0;
   logic [AXI_DATA_W-1:0] wdata = '0, rdata;
   logic [1:0]            bresp, rresp, last_b;
   logic                  awready, wready, bvalid, arready, rvalid, timer_irq;
   int                    n_errors = 0, total_checks = 0, cycles = 0;
   logic [15:0]           zl [10] = '{IDX_CMP_LOW, IDX_CMP_MID, IDX_CMP_HIGH, IDX_SNAP0_LOW,
      IDX_SNAP0_MID, IDX_SNAP0_HIGH, IDX_SNAP1_LOW, IDX_SNAP1_MID, IDX_SNAP1_HIGH, IDX_SNAP_CTRL};
   always #20 aclk = ~aclk;
   tick_counter tick_counter_inst (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
      .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(4'hF), .wvalid(wvalid),
      .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
      .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
      .rready(rready), .ext_irq_zero(ext_irq_zero), .ext_irq_one(ext_irq_one),
      .timer_irq(timer_irq));
   task automatic give_verdict;
      $display("checks %0d mismatches %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      total_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic wr(input logic [15:0] idx, input logic [7:0] d);
      awaddr <= {idx, 2'h0};
      wdata <= {24'h0, d};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
         if (bready && bvalid) begin
            last_b = bresp;
            bready <= 1'b0;
         end
      end while (awvalid || wvalid || bready);
   endtask
   task automatic rd(input logic [15:0] idx, output logic [31:0] d, output logic [1:0] r);
      araddr <= {idx, 2'h0};
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (arvalid && arready) arvalid <= 1'b0;
         if (rready && rvalid) begin
            d = rdata;
            r = rresp;
            rready <= 1'b0;
         end
      end while (arvalid || rready);
   endtask
   task automatic rc(input logic [15:0] idx, input logic [31:0] exp);
      logic [31:0] d;
      logic [1:0]  r;
      rd(idx, d, r);
      chk($sformatf("reg %h", idx), exp, d);
   endtask
   // two-cycle high pulse on both irq inputs, rising edge is the event
   task automatic pulse;
      ext_irq_zero <= 1'b1;
      ext_irq_one <= 1'b1;
      repeat (2) @(posedge aclk);
      ext_irq_zero <= 1'b0;
      ext_irq_one <= 1'b0;
      @(posedge aclk);
   endtask
   always @(posedge aclk) begin
      cycles++;
      if (cycles == 4000) begin
         n_errors++;
         give_verdict();
      end
   end
   initial begin
      logic [31:0] d;
      logic [1:0]  r;
      repeat (6) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (2) @(posedge aclk);
      foreach (zl[i]) rc(zl[i], 32'h0);
      rd(16'h0000, d, r);
      chk("rresp", {30'h0, RESP_SLVERR}, {30'h0, r});
      wr(16'h0000, 8'h5A);
      chk("bresp", {30'h0, RESP_SLVERR}, {30'h0, last_b});
      $display("test reset done");
      wr(IDX_RELOAD_LOW, 8'h11);
      wr(IDX_RELOAD_MID, 8'h22);
      wr(IDX_RELOAD_HI, 8'h33);
      wr(IDX_CTRL_TWO, 8'h04);
      wr(IDX_COUNT_LOW, 8'h99);
      wr(IDX_COUNT_MID, 8'h77);
      chk("bresp", {30'h0, RESP_OKAY}, {30'h0, last_b});
      rc(IDX_COUNT_LOW, 32'h11);
      rc(IDX_COUNT_MID, 32'h22);
      rc(IDX_COUNT_HIGH, 32'h33);
      wr(IDX_SNAP_CTRL, 8'h30);
      wr(IDX_SNAP_CTRL, 8'hF0);
      rc(IDX_SNAP_CTRL, 32'h30);
      rc(IDX_SNAP0_HIGH, 32'h33);
      rc(IDX_SNAP1_LOW, 32'h11);
      $display("test init and soft snapshot done");
      wr(IDX_CTRL_TWO, 8'h00);
      wr(IDX_COUNT_LOW, 8'h55);
      pulse();
      rc(IDX_SNAP0_MID, 32'h22);
      rc(IDX_SNAP1_MID, 32'h22);
      wr(IDX_SNAP_CTRL, 8'h00);
      pulse();
      rc(IDX_SNAP0_MID, 32'h00);
      rc(IDX_SNAP1_HIGH, 32'h00);
      $display("test hardware snapshot done");
      wr(IDX_RELOAD_LOW, 8'hFE);
      wr(IDX_RELOAD_MID, 8'hFF);
      wr(IDX_RELOAD_HI, 8'hFF);
      wr(IDX_CMP_LOW, 8'h02);
      wr(IDX_CTRL_TWO, 8'h04);
      wr(IDX_COUNT_LOW, 8'h00);
      wr(IDX_CTRL_ONE, 8'h03);
      wr(IDX_CTRL_TWO, 8'h42);
      // wrap past all ones reaches the compare value within a few ticks
      repeat (20) @(posedge aclk);
      chk("timer_irq", 32'h1, {31'h0, timer_irq});
      rc(IDX_CTRL_ONE, 32'h43);
      wr(IDX_CTRL_ONE, 8'h03);
      rc(IDX_CTRL_ONE, 32'h03);
      repeat (3) @(posedge aclk);
      chk("timer_irq", 32'h0, {31'h0, timer_irq});
      $display("test count and match done");
      // auto mode bounces between FFFFFE and FFFFFF; free-run would wrap to small values
      wr(IDX_CTRL_TWO, 8'h04);
      wr(IDX_COUNT_LOW, 8'h00);
      wr(IDX_CTRL_TWO, 8'h03);
      repeat (10) @(posedge aclk);
      wr(IDX_CTRL_TWO, 8'h01);
      rc(IDX_COUNT_HIGH, 32'hFF);
      rc(IDX_COUNT_MID, 32'hFF);
      // about 28 running cycles at /8 give four ticks; /4, /2 or /1 would give more
      wr(IDX_CTRL_TWO, 8'h00);
      wr(IDX_COUNT_LOW, 8'h00);
      wr(IDX_CTRL_ONE, 8'h00);
      wr(IDX_CTRL_TWO, 8'h02);
      repeat (25) @(posedge aclk);
      wr(IDX_CTRL_TWO, 8'h00);
      rc(IDX_COUNT_LOW, 32'h04);
      $display("test reload and prescale done");
      give_verdict();
   end
endmodule
